// >>> rtl/adc_startup_regs.vh
// Register map, field positions, reset values and timing counts for the start-up sequencer.
// Assumes a 100 MHz register clock and a 32-bit AXI4-Lite register bus.
`ifndef ADC_STARTUP_REGS_VH
`define ADC_STARTUP_REGS_VH

// Byte offsets of the three registers
`define REG_CTRL_OFS            4'h0
`define REG_MODE_OFS            4'h4
`define REG_STATUS_OFS          4'h8

// Control register fields
`define CTRL_LINK_EN_BIT        0
`define CTRL_CAL_EN_BIT         1
`define CTRL_SYNC_SEL_BIT       2
`define CTRL_OVERRANGE_ENABLE_BIT         3
`define CTRL_CAL_TRIG_BIT       4
`define CTRL_CAL_BG_BIT         5
`define CTRL_OFS_CAL_BIT        6
`define CTRL_WIDTH              7
`define CTRL_RESET              7'h03

// Mode register fields
`define MODE_LINK_MODE_SELECT_LSB          0
`define MODE_LINK_MODE_SELECT_MSB          4
`define MODE_KM1_LSB            8
`define MODE_KM1_MSB            12
`define MODE_RESET              32'h0000_1F00
`define SINGLE_CH_LAST_MODE     5'h01

// Link and calibration state codes
`define LINK_HALT               2'h0
`define LINK_CGS                2'h1
`define LINK_ILAS               2'h2
`define LINK_DATA               2'h3
`define CAL_IDLE                2'h0
`define CAL_RUN                 2'h1
`define CAL_DONE                2'h2

// Timing: one calibration run, and number of multiframes in the lane alignment sequence
`define CAL_RUN_NS              1000
`define CLK_PERIOD_NS           10
`define CAL_RUN_CYCLES          (`CAL_RUN_NS / `CLK_PERIOD_NS)
`define ILAS_MULTIFRAMES        4

// AXI response codes
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

// >>> rtl/pin_sync3.v
// Three-flop input synchroniser, one lane per bit, with agreement filter.
// Assumes asynchronous pin levels; output changes only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] pin_in,
    input  wire [WIDTH-1:0] reset_level,
    output wire [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : lane
            reg s1_r;      // Metastability catcher, read only by s2
            reg s2_r;      // Second stage
            reg s3_r;      // Third stage
            reg stable_r;  // Filtered level
            // Clocked chain; the reset level is sampled by a clocked process, not latched async
            always @(posedge aclk) begin
                if (!aresetn) begin
                    s1_r     <= reset_level[i];
                    s2_r     <= reset_level[i];
                    s3_r     <= reset_level[i];
                    stable_r <= reset_level[i];
                end else begin
                    s1_r <= pin_in[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // Accept a change only once two stages agree
                    if (s2_r == s3_r) begin
                        stable_r <= s3_r;
                    end
                end
            end
            assign level_out[i] = stable_r;
        end
    endgenerate
endmodule

// >>> rtl/adc_startup_sequencer.v
// Start-up sequencer: register file over AXI4-Lite, link and calibration state machines,
// and regulator enable sequencing. Assumes one 100 MHz clock and asynchronous pin inputs.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_startup_regs.vh"
module adc_startup_sequencer (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Link pins
    input  wire        single_ended_sync_n,
    input  wire        timestamp_sync_n,
    output reg  [1:0]  link_char_sel,
    output reg  [4:0]  link_mode_out,
    output reg  [4:0]  multiframe_len_minus_one,
    output reg         dual_edge_sample,
    output reg         overrange_enable,
    // Calibration
    output reg         cal_running,
    output reg         cal_background,
    output reg         cal_offset_en,
    // Power sequencing
    input  wire        analog_supply_high_pgood,
    output wire        core_supply_low_enable
);
    // Register file
    reg  [`CTRL_WIDTH-1:0] ctrl_r;        // Control bits
    reg  [31:0]            mode_r;        // Link mode and multiframe length
    reg  [1:0]             link_state_r;  // Link state machine
    reg  [1:0]             cal_state_r;   // Calibration state machine
    reg  [15:0]            cal_cnt_r;     // Calibration run counter
    reg  [8:0]             ilas_cnt_r;    // Frames left in the alignment sequence
    reg                    trig_prev_r;   // Trigger value before the latest write
    reg                    cal_en_prev_r; // Calibration enable one cycle ago
    reg                    pg_en_r;       // Power-good seen stable
    // Write channel capture
    reg                    aw_got_r;
    reg  [3:0]             aw_addr_r;
    reg                    w_got_r;
    reg  [31:0]            w_data_r;
    reg  [3:0]             w_strb_r;

    // Synchronised pin levels: {pgood, timestamp, single-ended}
    wire [2:0] pins_sync;
    pin_sync3 #(
        .WIDTH(3)
    ) u_pin_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     ({analog_supply_high_pgood, timestamp_sync_n, single_ended_sync_n}),
        .reset_level(3'b011),
        .level_out  (pins_sync)
    );

    // Pick the sync request source
    wire sync_req_n = ctrl_r[`CTRL_SYNC_SEL_BIT] ? pins_sync[1] : pins_sync[0];

    // Write handshake: address and data may arrive in either order
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    wire        aw_now   = aw_got_r | (s_axi_awvalid & s_axi_awready);
    wire        w_now    = w_got_r | (s_axi_wvalid & s_axi_wready);
    wire [3:0]  wr_addr  = aw_got_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data  = w_got_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb  = w_got_r ? w_strb_r : s_axi_wstrb;
    wire        wr_fire  = aw_now && w_now && !s_axi_bvalid;
    wire        wr_ctrl  = wr_fire && (wr_addr[3:2] == `REG_CTRL_OFS >> 2);
    wire        wr_mode  = wr_fire && (wr_addr[3:2] == `REG_MODE_OFS >> 2);
    wire        wr_known = wr_ctrl || wr_mode || (wr_addr[3:2] == `REG_STATUS_OFS >> 2);
    assign s_axi_arready = !s_axi_rvalid;

    // Byte-lane merge for the two writable registers
    reg [31:0] ctrl_wide;
    reg [31:0] mode_nxt;
    integer b;
    always @* begin
        ctrl_wide = {25'h0, ctrl_r};
        mode_nxt  = mode_r;
        for (b = 0; b < 4; b = b + 1) begin
            if (wr_strb[b]) begin
                ctrl_wide[b*8 +: 8] = wr_data[b*8 +: 8];
                mode_nxt[b*8 +: 8]  = wr_data[b*8 +: 8];
            end
        end
    end

    // Register writes and write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r       <= `CTRL_RESET;
            mode_r       <= `MODE_RESET;
            aw_got_r     <= 1'b0;
            aw_addr_r    <= 4'h0;
            w_got_r      <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
            trig_prev_r  <= 1'b0;
        end else begin
            // Hold whichever half arrived first
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status is read-only; writing it is harmless but unmapped is an error
                s_axi_bresp  <= wr_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                if (wr_ctrl) begin
                    ctrl_r      <= ctrl_wide[`CTRL_WIDTH-1:0];
                    trig_prev_r <= ctrl_r[`CTRL_CAL_TRIG_BIT];
                end
                // Mode is taken as written; the host is trusted to halt first
                if (wr_mode) begin
                    mode_r <= mode_nxt;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path: answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `AXI_RESP_OKAY;
            case (s_axi_araddr[3:2])
                `REG_CTRL_OFS >> 2: s_axi_rdata <= {25'h0, ctrl_r};
                `REG_MODE_OFS >> 2: s_axi_rdata <= {19'h0, mode_r[12:8], 3'h0, mode_r[4:0]};
                `REG_STATUS_OFS >> 2: begin
                    // Live state of both machines, sync request and supply
                    s_axi_rdata <= {24'h0, core_supply_low_enable, pins_sync[2], sync_req_n,
                                    1'b0, cal_state_r, link_state_r};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AXI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Frames in the alignment sequence: K is the field plus one
    wire [31:0] ilas_frames_w = (mode_r[`MODE_KM1_MSB:`MODE_KM1_LSB] + 32'd1) * `ILAS_MULTIFRAMES;
    wire [8:0]  ilas_frames   = ilas_frames_w[8:0];

    // Link state machine
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_state_r <= `LINK_HALT;
            ilas_cnt_r   <= 9'h000;
        end else if (!ctrl_r[`CTRL_LINK_EN_BIT]) begin
            // Disabled link sits in halt so settings can change
            link_state_r <= `LINK_HALT;
        end else begin
            case (link_state_r)
                `LINK_HALT: link_state_r <= `LINK_CGS; // Re-enable restarts the link
                `LINK_CGS: begin
                    // Leave code-group sync once the receiver releases its request
                    if (sync_req_n) begin
                        link_state_r <= `LINK_ILAS;
                        ilas_cnt_r   <= ilas_frames - 9'd1;
                    end
                end
                `LINK_ILAS: begin
                    if (!sync_req_n) begin
                        link_state_r <= `LINK_CGS; // Resync request restarts
                    end else if (ilas_cnt_r == 9'h000) begin
                        link_state_r <= `LINK_DATA;
                    end else begin
                        ilas_cnt_r <= ilas_cnt_r - 9'd1;
                    end
                end
                `LINK_DATA: begin
                    if (!sync_req_n) begin
                        link_state_r <= `LINK_CGS;
                    end
                end
                default: link_state_r <= `LINK_HALT;
            endcase
        end
    end

    // Calibration state machine
    reg  trig_seen_r; // Edge consumed so it starts one run only
    wire trig_rise = ctrl_r[`CTRL_CAL_TRIG_BIT] && !trig_prev_r;
    wire cal_start = (ctrl_r[`CTRL_CAL_EN_BIT] && !cal_en_prev_r) || (trig_rise && !trig_seen_r);
    wire [31:0] cal_load_w = `CAL_RUN_CYCLES - 1; // Kept wide, then cut to the counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            cal_state_r   <= `CAL_IDLE;
            cal_cnt_r     <= 16'h0000;
            cal_en_prev_r <= 1'b0;
            trig_seen_r   <= 1'b0;
        end else begin
            cal_en_prev_r <= ctrl_r[`CTRL_CAL_EN_BIT];
            trig_seen_r   <= trig_rise;
            if (!ctrl_r[`CTRL_CAL_EN_BIT]) begin
                cal_state_r <= `CAL_IDLE; // Halted while disabled
            end else begin
                case (cal_state_r)
                    `CAL_IDLE, `CAL_DONE: begin
                        // Enable or trigger 0-to-1 starts a run
                        if (cal_start) begin
                            cal_state_r <= `CAL_RUN;
                            cal_cnt_r   <= cal_load_w[15:0];
                        end
                    end
                    `CAL_RUN: begin
                        if (cal_cnt_r == 16'h0000) begin // Background mode keeps recalibrating
                            cal_state_r <= ctrl_r[`CTRL_CAL_BG_BIT] ? `CAL_RUN : `CAL_DONE;
                            cal_cnt_r   <= cal_load_w[15:0];
                        end else begin
                            cal_cnt_r <= cal_cnt_r - 16'd1;
                        end
                    end
                    default: cal_state_r <= `CAL_IDLE;
                endcase
            end
        end
    end

    // Registered outputs to the datapath
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_char_sel            <= `LINK_HALT;
            link_mode_out            <= 5'h00;
            multiframe_len_minus_one <= 5'h1F;
            dual_edge_sample         <= 1'b1;
            overrange_enable         <= 1'b0;
            cal_running              <= 1'b0;
            cal_background           <= 1'b0;
            cal_offset_en            <= 1'b0;
            pg_en_r                  <= 1'b0;
        end else begin
            link_char_sel            <= link_state_r;
            link_mode_out            <= mode_r[`MODE_LINK_MODE_SELECT_MSB:`MODE_LINK_MODE_SELECT_LSB];
            multiframe_len_minus_one <= mode_r[`MODE_KM1_MSB:`MODE_KM1_LSB];
            // Single-channel modes interleave on both edges; clock rate is unchanged
            dual_edge_sample <= (mode_r[`MODE_LINK_MODE_SELECT_MSB:`MODE_LINK_MODE_SELECT_LSB] <= `SINGLE_CH_LAST_MODE);
            overrange_enable         <= ctrl_r[`CTRL_OVERRANGE_ENABLE_BIT];
            cal_running              <= (cal_state_r == `CAL_RUN);
            cal_background           <= ctrl_r[`CTRL_CAL_BG_BIT];
            cal_offset_en            <= ctrl_r[`CTRL_OFS_CAL_BIT];
            pg_en_r                  <= pins_sync[2]; // Enable only after stable power-good
        end
    end

    // Raw pin gates the enable so a supply loss drops it at once, without sync delay
    assign core_supply_low_enable = pg_en_r & analog_supply_high_pgood;
endmodule

// >>> testbench/sync_receiver.sv
// Link receiver model: holds the sync request low until code groups are stable.
// Assumes the sequencer's link state output and a bench-driven resync request.
`timescale 1ns/100ps
`include "adc_startup_regs.vh"
module sync_receiver #(
    parameter LOCK_CYC = 8
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [1:0] link_char_sel,
    input  wire       resync,
    output reg        rx_sync_n
);
    reg [3:0] lock_r; // Code-group cycles seen so far
    // Request is active low; released only after a run of code groups, like a real receiver
    always @(posedge aclk) begin
        if (!aresetn || resync || link_char_sel == `LINK_HALT) begin
            rx_sync_n <= 1'b0;
            lock_r    <= 4'h0;
        end else if (link_char_sel == `LINK_CGS) begin
            lock_r    <= (lock_r == LOCK_CYC) ? lock_r : lock_r + 4'h1;
            rx_sync_n <= (lock_r == LOCK_CYC);
        end
    end
endmodule

// >>> testbench/adc_startup_sequencer_chk.sv
// Checker: timing relations between the sequencer's ports.
// Assumes it is bound into the sequencer and sees only its ports.
`timescale 1ns/100ps
`include "adc_startup_regs.vh"
module adc_startup_sequencer_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_arready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [1:0]  link_char_sel,
    input wire [4:0]  link_mode_out,
    input wire [4:0]  multiframe_len_minus_one,
    input wire        dual_edge_sample,
    input wire        cal_running,
    input wire        analog_supply_high_pgood,
    input wire        core_supply_low_enable
);
    reg [7:0] ilas_cnt_r; // Cycles spent in lane alignment
    // Restarts whenever alignment is left, so each pass is measured alone
    always @(posedge aclk) begin
        if (!aresetn || link_char_sel != `LINK_ILAS)
            ilas_cnt_r <= 8'h00;
        else
            ilas_cnt_r <= ilas_cnt_r + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_CORE_NEEDS_PGOOD: assert property (
        core_supply_low_enable |-> analog_supply_high_pgood)
        else $error("core enable high without analog power-good");
    AST_CORE_RISE: assert property (
        analog_supply_high_pgood [*7] |-> core_supply_low_enable)
        else $error("core enable late after power-good");
    AST_DUAL_EDGE: assert property (
        dual_edge_sample == (link_mode_out <= `SINGLE_CH_LAST_MODE))
        else $error("dual-edge sampling does not match link mode");
    AST_HALT_EXIT: assert property (
        link_char_sel == `LINK_HALT ##1 link_char_sel != `LINK_HALT |-> link_char_sel == `LINK_CGS)
        else $error("link left halt to a state other than code-group sync");
    AST_ILAS_ENTRY: assert property (
        link_char_sel == `LINK_ILAS && $past(link_char_sel) != `LINK_ILAS
        |-> $past(link_char_sel) == `LINK_CGS)
        else $error("lane alignment entered not from code-group sync");
    AST_DATA_ENTRY: assert property (
        link_char_sel == `LINK_DATA && $past(link_char_sel) != `LINK_DATA
        |-> $past(link_char_sel) == `LINK_ILAS)
        else $error("data entered not from lane alignment");
    AST_ILAS_LEN: assert property (
        link_char_sel == `LINK_ILAS ##1 link_char_sel == `LINK_DATA
        |-> ilas_cnt_r == `ILAS_MULTIFRAMES * (multiframe_len_minus_one + 1))
        else $error("lane alignment length wrong");
    AST_BVALID_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_RVALID_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_ARREADY: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready while data pending");
    cover property (link_char_sel == `LINK_DATA);
    cover property ($fell(cal_running));
    cover property ($rose(core_supply_low_enable));
endmodule

// >>> testbench/test_adc_startup_sequencer.sv
// Bench for the start-up sequencer: AXI4-Lite master tasks, sync receiver, supply level.
// Assumes the register map header and that all tasks start and end just after a clock edge.
`timescale 1ns/100ps
`include "adc_startup_regs.vh"
module test_adc_startup_sequencer;
    reg         aclk = 0, aresetn = 0;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0000_0000;
    reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    wire [3:0]  s_axi_wstrb = 4'hf; // Whole words only
    reg         s_axi_bready = 1, s_axi_rready = 1; // Dropped once to test answer holding
    reg         analog_supply_high_pgood = 0, resync = 0, ts_sel = 0;
    wire        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    wire        rx_sync_n, dual_edge_sample, overrange_enable, cal_running;
    wire        cal_background, cal_offset_en, core_supply_low_enable;
    wire [1:0]  s_axi_bresp, s_axi_rresp, link_char_sel;
    wire [31:0] s_axi_rdata;
    wire [4:0]  link_mode_out, multiframe_len_minus_one;
    // Unselected source is held requesting, so a wrong selection cannot reach data
    wire        single_ended_sync_n = ts_sel ? 1'b0 : rx_sync_n;
    wire        timestamp_sync_n = ts_sel ? rx_sync_n : 1'b0;
    int         n_fail = 0, check_count = 0, cycles = 0, n;
    adc_startup_sequencer dut (.*);
    sync_receiver rx (.*);
    initial forever #5 aclk = ~aclk; // Clock runs before any access
    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string what, input [31:0] exp, input [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One write, both halves offered together, response awaited
    task wr(input [3:0] a, input [31:0] d, input [1:0] exp_r);
        bit done;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) done = 1;
            if (s_axi_bvalid) s_axi_bready <= 1;
        end
        check("bresp", exp_r, s_axi_bresp);
    endtask
    task rd(input [3:0] a, input [31:0] exp_d, input [1:0] exp_r);
        bit done;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && s_axi_rready) done = 1;
            if (s_axi_rvalid) s_axi_rready <= 1;
        end
        check("rdata", exp_d, s_axi_rdata);
        check("rresp", exp_r, s_axi_rresp);
    endtask
    // State selector: 0 calibration running, 1..4 link state code plus one
    function bit cur(input int s);
        cur = (s == 0) ? (cal_running === 1'b1) : (link_char_sel === s - 1);
    endfunction
    task wait_on(input int s, input string what);
        int k;
        k = 0;
        while (!cur(s) && k < 300) begin
            @(posedge aclk);
            k++;
        end
        check(what, 1, cur(s));
    endtask
    task span(input int s, output int len);
        len = 0;
        while (cur(s) && len < 400) begin
            len++;
            @(posedge aclk);
        end
    endtask
    task t_reset;
        check("kminus1", 5'h1F, multiframe_len_minus_one);
        check("dual edge", 1, dual_edge_sample);
        check("core en", 0, core_supply_low_enable);
        rd(`REG_CTRL_OFS, `CTRL_RESET, `AXI_RESP_OKAY);
        rd(`REG_MODE_OFS, `MODE_RESET, `AXI_RESP_OKAY);
        s_axi_rready <= 0;
        rd(4'hC, 32'h0000_0000, `AXI_RESP_SLVERR);
        s_axi_bready <= 0;
        wr(4'hC, 32'h0000_0000, `AXI_RESP_SLVERR);
        wr(`REG_STATUS_OFS, 32'hFFFF_FFFF, `AXI_RESP_OKAY);
        rd(`REG_CTRL_OFS, `CTRL_RESET, `AXI_RESP_OKAY);
        wait_on(4, "data after reset");
        rd(`REG_STATUS_OFS, 32'h0000_002B, `AXI_RESP_OKAY);
        $display("test reset done");
    endtask
    task t_power;
        analog_supply_high_pgood <= 1;
        repeat (3) @(posedge aclk);
        check("core en early", 0, core_supply_low_enable);
        repeat (5) @(posedge aclk);
        check("core en", 1, core_supply_low_enable);
        analog_supply_high_pgood <= 0;
        #1 check("core en drop", 0, core_supply_low_enable);
        @(posedge aclk);
        analog_supply_high_pgood <= 1;
        repeat (8) @(posedge aclk);
        $display("test power done");
    endtask
    task t_sequence;
        wr(`REG_CTRL_OFS, 32'h0000_0000, `AXI_RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("link halt", `LINK_HALT, link_char_sel);
        wr(`REG_MODE_OFS, 32'h0000_0302, `AXI_RESP_OKAY);
        @(posedge aclk);
        check("link mode", 5'h02, link_mode_out);
        check("kminus1", 5'h03, multiframe_len_minus_one);
        check("dual edge", 0, dual_edge_sample);
        rd(`REG_MODE_OFS, 32'h0000_0302, `AXI_RESP_OKAY);
        wr(`REG_CTRL_OFS, 32'h0000_0044, `AXI_RESP_OKAY);
        ts_sel <= 1;
        @(posedge aclk);
        check("offset cal", 1, cal_offset_en);
        check("cal idle", 0, cal_running);
        wr(`REG_CTRL_OFS, 32'h0000_0046, `AXI_RESP_OKAY);
        wait_on(0, "cal start");
        span(0, n);
        check("cal cycles", `CAL_RUN_CYCLES, n);
        wr(`REG_CTRL_OFS, 32'h0000_004E, `AXI_RESP_OKAY);
        @(posedge aclk);
        check("overrange", 1, overrange_enable);
        wr(`REG_CTRL_OFS, 32'h0000_004F, `AXI_RESP_OKAY);
        wait_on(2, "cgs");
        wait_on(3, "ilas");
        span(3, n);
        check("ilas cycles", 16, n);
        check("data", `LINK_DATA, link_char_sel);
        resync <= 1;
        @(posedge aclk);
        resync <= 0;
        wait_on(2, "resync cgs");
        wait_on(4, "resync data");
        wr(`REG_CTRL_OFS, 32'h0000_004B, `AXI_RESP_OKAY);
        wait_on(2, "source switch cgs");
        repeat (20) @(posedge aclk);
        check("held in cgs", `LINK_CGS, link_char_sel);
        ts_sel <= 0;
        wait_on(4, "single-ended data");
        $display("test sequence done");
    endtask
    task t_trigger;
        wr(`REG_CTRL_OFS, 32'h0000_005B, `AXI_RESP_OKAY);
        wait_on(0, "trigger start");
        span(0, n);
        check("trigger cycles", `CAL_RUN_CYCLES, n);
        wr(`REG_CTRL_OFS, 32'h0000_005B, `AXI_RESP_OKAY);
        repeat (5) @(posedge aclk);
        check("no retrigger", 0, cal_running);
        wr(`REG_CTRL_OFS, 32'h0000_004B, `AXI_RESP_OKAY);
        wr(`REG_CTRL_OFS, 32'h0000_005B, `AXI_RESP_OKAY);
        wait_on(0, "second trigger");
        wr(`REG_CTRL_OFS, 32'h0000_0049, `AXI_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("cal abort", 0, cal_running);
        wr(`REG_CTRL_OFS, 32'h0000_006B, `AXI_RESP_OKAY);
        @(posedge aclk);
        check("background", 1, cal_background);
        wait_on(0, "background start");
        $display("test trigger done");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_power;
        t_sequence;
        t_trigger;
        report_and_stop;
    end
endmodule
bind adc_startup_sequencer adc_startup_sequencer_chk chk (.*);
